// ==== asf_pkg.sv ====
// Shared constants, types and sweep tables for the converter sequencer
package asf_pkg;

    localparam int DEPTH      = 8;
    localparam int IDX_W      = 3;
    localparam int RES_W      = 14;
    localparam int WORD_W     = 16;
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 16;

    // Register port byte addresses
    localparam logic [ADDR_W-1:0] CONFIG_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] CMD_ADDR    = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] RESULT_ADDR = 4'hC;

    // Command register fields
    localparam int CMD_READ_BIT = 3;
    localparam int CMD_CH_LSB   = 0;

    // Conversion modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_SWEEP  = 2'h2;
    localparam logic [1:0] MODE_RSWEEP = 2'h3;

    // Threshold codes
    localparam logic [1:0] THR_FULL    = 2'h0;
    localparam logic [1:0] THR_3Q      = 2'h1;
    localparam logic [1:0] THR_HALF    = 2'h2;
    localparam logic [1:0] THR_1Q      = 2'h3;

    // Conversion timing
    localparam int CLKS_14BIT     = 18;
    localparam int CLKS_12BIT     = 13;
    localparam int SCLK_DIV       = 4;
    localparam int OSC_DIV        = 6;
    localparam int TAIL_NS        = 15;
    localparam int MCLK_PERIOD_NS = 25;
    localparam int TAIL_CYC_RAW   =
        (TAIL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int TAIL_CYC       = (TAIL_CYC_RAW < 1) ? 1 : TAIL_CYC_RAW;

    typedef struct packed {
        logic       res12;
        logic       clk_ext;
        logic [1:0] thr;
        logic [1:0] seq_sel;
        logic [1:0] mode;
    } asf_cfg_t;

    localparam asf_cfg_t CFG_RESET = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } asf_bus_t;

    typedef enum logic [1:0] {
        ST_PDOWN,
        ST_IDLE,
        ST_CONV
    } asf_state_t;

    // Fill count that trips the interrupt
    function automatic logic [IDX_W:0] asf_thr_count(input logic [1:0] thr);
        case (thr)
            THR_3Q:   asf_thr_count = 4'h6;
            THR_HALF: asf_thr_count = 4'h4;
            THR_1Q:   asf_thr_count = 4'h2;
            default:  asf_thr_count = 4'h8;
        endcase
    endfunction

    // Channel at a given sweep position
    function automatic logic [2:0] asf_sweep_ch(input logic [1:0] sel,
                                                input logic [2:0] pos);
        case (sel)
            2'h1:    asf_sweep_ch = {pos[1:0], 1'b0};
            2'h2:    asf_sweep_ch = {pos[2:1], 1'b0};
            2'h3:    asf_sweep_ch = {1'b0, pos[1:0]};
            default: asf_sweep_ch = pos;
        endcase
    endfunction

endpackage

// ==== asf_conv_timer.sv ====
// Conversion clock selection and conversion length counter
`timescale 1ns/10ps
module asf_conv_timer
    import asf_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic clk_ext_i,
    input  wire logic res12_i,
    input  wire logic sclk_rise_i,
    output logic      busy_o,
    output logic      done_o
);
    logic [2:0] osc_cnt;
    logic [1:0] sclk_cnt;
    logic [4:0] tick_cnt;
    logic [1:0] tail_cnt;
    logic       in_tail;

    wire        osc_tick  = (osc_cnt == 3'(OSC_DIV - 1));
    wire        sclk_tick = sclk_rise_i && (sclk_cnt == 2'(SCLK_DIV - 1));
    wire        conv_tick = clk_ext_i ? sclk_tick : osc_tick;
    wire  [4:0] tick_need = res12_i ? 5'(CLKS_12BIT) : 5'(CLKS_14BIT);
    wire        last_tick = conv_tick && (tick_cnt == tick_need - 5'h1);
    wire        tail_end  = in_tail && (tail_cnt == 2'(TAIL_CYC - 1));

    // Free-running divider stands in for the internal oscillator
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || osc_tick)
            osc_cnt <= 3'h0;
        else
            osc_cnt <= osc_cnt + 3'h1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || start_i)
            sclk_cnt <= 2'h0;
        else if (sclk_rise_i)
            sclk_cnt <= sclk_cnt + 2'h1;
    end

    // Clock count, then the fixed tail
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            busy_o   <= 1'b0;
            in_tail  <= 1'b0;
            tick_cnt <= 5'h0;
            tail_cnt <= 2'h0;
            done_o   <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_o)
            begin
                busy_o   <= 1'b1;
                tick_cnt <= 5'h0;
                tail_cnt <= 2'h0;
                in_tail  <= 1'b0;
            end
            else if (busy_o && !in_tail && last_tick)
                in_tail <= 1'b1;
            else if (busy_o && !in_tail && conv_tick)
                tick_cnt <= tick_cnt + 5'h1;
            else if (tail_end)
            begin
                busy_o  <= 1'b0;
                in_tail <= 1'b0;
                done_o  <= 1'b1;
            end
            else if (in_tail)
                tail_cnt <= tail_cnt + 2'h1;
        end
    end
endmodule

// ==== asf_ctrl.sv ====
// Sequencer, result buffer and power control of the converter
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module asf_ctrl
(
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    input  wire logic                      cs_n_i,
    input  wire logic                      frame_sync_pulse_i,
    input  wire logic                      conversion_start_strobe_n_i,
    input  wire logic                      sclk_i,
    input  wire logic [asf_pkg::RES_W-1:0] adc_result_i,
    input  wire logic [asf_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [asf_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic [asf_pkg::DATA_W-1:0]     rdata_o,
    output logic [asf_pkg::WORD_W-1:0]     output_result_word_o,
    output logic [2:0]                     channel_o,
    output logic                           sample_o,
    output logic                           conv_done_o,
    output logic                           threshold_int_o,
    output logic                           power_down_o
);
    import asf_pkg::*;

    asf_bus_t               bus;
    asf_cfg_t               config_register;
    asf_state_t             state;
    asf_state_t             next_state;
    logic [RES_W-1:0]       buf_mem [DEPTH];
    logic [IDX_W:0]         fill;
    logic [IDX_W:0]         next_fill;
    logic [IDX_W-1:0]       rd_idx;
    logic                   reading;
    logic                   presented;
    logic [2:0]             sel_ch;
    logic [RES_W-1:0]       single_res;
    logic [2:0]             cs_sync;
    logic [2:0]             fs_sync;
    logic [2:0]             cst_sync;
    logic [2:0]             sclk_sync;
    logic                   timer_busy;
    logic                   timer_done;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Pins pass two flops; bit 2 is only a delayed copy for edges
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cs_sync   <= 3'h7;
            fs_sync   <= 3'h0;
            cst_sync  <= 3'h7;
            sclk_sync <= 3'h0;
        end
        else
        begin
            cs_sync   <= {cs_sync[1:0], cs_n_i};
            fs_sync   <= {fs_sync[1:0], frame_sync_pulse_i};
            cst_sync  <= {cst_sync[1:0], conversion_start_strobe_n_i};
            sclk_sync <= {sclk_sync[1:0], sclk_i};
        end
    end

    wire cs_fall    = cs_sync[2] && !cs_sync[1];
    wire fs_rise    = !fs_sync[2] && fs_sync[1];
    wire cst_fall   = cst_sync[2] && !cst_sync[1];
    wire sclk_rise  = !sclk_sync[2] && sclk_sync[1];
    wire trigger    = cs_fall || fs_rise || cst_fall;

    // Register port decode
    wire cfg_wr     = bus.wr && (bus.addr == CONFIG_ADDR);
    wire cmd_wr     = bus.wr && (bus.addr == CMD_ADDR);
    wire res_rd     = bus.rd && (bus.addr == RESULT_ADDR);
    wire cmd_read   = cmd_wr && bus.wdata[CMD_READ_BIT];
    wire cmd_other  = cmd_wr && !bus.wdata[CMD_READ_BIT];

    wire [1:0]       mode     = config_register.mode;
    wire             use_buf  = (mode != MODE_SINGLE);
    wire             sweeping = mode[1];
    wire [IDX_W:0]   thr_cnt  = asf_thr_count(config_register.thr);
    wire             thr_hit  = use_buf && (fill >= thr_cnt);
    wire             wrap     = (mode == MODE_RSWEEP) && thr_hit;
    // Modes 01 and 10 hold off until the host drains the buffer
    wire             blocked  = use_buf && thr_hit && !wrap;
    wire [IDX_W-1:0] wr_pos   = wrap ? '0 : fill[IDX_W-1:0];
    // Sweep position follows the fill count, so an emptied buffer
    // after power-down restarts the sweep at its first channel
    wire [2:0]       conv_ch  = sweeping ?
                                asf_sweep_ch(config_register.seq_sel,
                                             wr_pos) : sel_ch;
    // Config writes and buffer reads never start a conversion
    wire             start    = trigger && !cfg_wr && !cmd_wr && !res_rd
                                && !blocked && !reading && !timer_busy
                                && (state != ST_CONV);
    wire             conv_end = timer_done && (state == ST_CONV);
    wire             last_pop = res_rd && reading
                                && ({1'b0, rd_idx} == fill - 4'h1);
    wire             pres_now = (threshold_int_o || reading) && !presented;
    // Commands other than a buffer read abandon the drain
    wire             abandon  = (reading || presented)
                                && cmd_other;

    wire [RES_W-1:0] head     = buf_mem[rd_idx];
    wire [RES_W-1:0] out_src  = use_buf ? head : single_res;
    wire [WORD_W-1:0] out_word = config_register.res12 ?
                                {out_src[11:0], 4'h0} :
                                {out_src, 2'h0};

    // Auto power-down after every conversion, wake on any trigger
    always_comb
    begin
        next_state = state;
        case (state)
            ST_PDOWN:
                if (trigger)
                    next_state = start ? ST_CONV : ST_IDLE;
            ST_IDLE:
                if (start)
                    next_state = ST_CONV;
            ST_CONV:
                if (timer_done)
                    next_state = ST_PDOWN;
            default:
                next_state = ST_PDOWN;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            state <= ST_PDOWN;
        else
            state <= next_state;
    end

    // Fill count: conversions add, config writes and drains clear
    always_comb
    begin
        next_fill = fill;
        if (cfg_wr || abandon || last_pop)
            next_fill = '0;
        else if (conv_end && use_buf)
            next_fill = (wrap ? 4'h0 : fill) + 4'h1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            fill <= '0;
        else
            fill <= next_fill;
    end

    // Entries change only on a finished conversion
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_entry
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                    buf_mem[gi] <= '0;
                else if (conv_end && use_buf && wr_pos == IDX_W'(gi))
                    buf_mem[gi] <= adc_result_i;
            end
        end
    endgenerate

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            single_res <= '0;
        else if (conv_end && !use_buf)
            single_res <= adc_result_i;
    end

    // Configuration and channel select
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            config_register <= CFG_RESET;
            sel_ch          <= 3'h0;
        end
        else
        begin
            if (cfg_wr)
                config_register <= asf_cfg_t'(bus.wdata[7:0]);
            if (cmd_other)
                sel_ch <= bus.wdata[CMD_CH_LSB +: 3];
        end
    end

    // Drain tracking and early presentation of the first entry
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            reading   <= 1'b0;
            presented <= 1'b0;
            rd_idx    <= '0;
        end
        else if (cfg_wr || abandon || last_pop)
        begin
            reading   <= 1'b0;
            presented <= 1'b0;
            rd_idx    <= '0;
        end
        else
        begin
            if (threshold_int_o && !reading)
                presented <= 1'b1;
            if (cmd_read && use_buf && fill != '0)
                reading <= 1'b1;
            if (res_rd && reading)
            begin
                rd_idx    <= rd_idx + 3'h1;
                presented <= 1'b0;
            end
        end
    end

    // Interrupt stays up until a drain begins or the buffer clears
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            threshold_int_o <= 1'b0;
        else if (conv_end && use_buf && (next_fill >= thr_cnt))
            threshold_int_o <= 1'b1;
        else if (cmd_read || cfg_wr || abandon)
            threshold_int_o <= 1'b0;
    end

    // Done flag set by a conversion end, cleared by the next start or a config write
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            conv_done_o <= 1'b0;
        else if (conv_end)
            conv_done_o <= 1'b1;
        else if (start || cfg_wr)
            conv_done_o <= 1'b0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            output_result_word_o <= '0;
        else if (cfg_wr || abandon)
            output_result_word_o <= '0;
        else if (pres_now || (conv_end && !use_buf))
            output_result_word_o <= use_buf ? out_word :
                                    (config_register.res12 ?
                                     {adc_result_i[11:0], 4'h0} :
                                     {adc_result_i, 2'h0});
        else if (presented || reading)
            output_result_word_o <= out_word;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else if (bus.rd)
            case (bus.addr)
                CONFIG_ADDR: rdata_o <= {8'h00, config_register};
                STATUS_ADDR: rdata_o <= {7'h00, reading, fill,
                                         (state == ST_CONV),
                                         power_down_o, threshold_int_o,
                                         conv_done_o};
                RESULT_ADDR: rdata_o <= out_word;
                default:     rdata_o <= '0;
            endcase
        else
            rdata_o <= '0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            channel_o    <= 3'h0;
            sample_o     <= 1'b0;
            power_down_o <= 1'b1;
        end
        else
        begin
            sample_o     <= start;
            power_down_o <= (next_state == ST_PDOWN);
            if (start)
                channel_o <= conv_ch;
        end
    end

    asf_conv_timer u_timer
    (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .start_i     (start),
        .clk_ext_i   (config_register.clk_ext),
        .res12_i     (config_register.res12),
        .sclk_rise_i (sclk_rise),
        .busy_o      (timer_busy),
        .done_o      (timer_done)
    );
endmodule

// ==== asf_ctrl_assertions.sv ====
// Port-level concurrent checks for the converter sequencer
`timescale 1ns/10ps
module asf_ctrl_assertions
(
    input wire logic                       mclk_i,
    input wire logic                       rst_i,
    input wire logic [asf_pkg::ADDR_W-1:0] addr_i,
    input wire logic [asf_pkg::DATA_W-1:0] wdata_i,
    input wire logic                       wr_i,
    input wire logic                       rd_i,
    input wire logic [asf_pkg::WORD_W-1:0] output_result_word_o,
    input wire logic                       sample_o,
    input wire logic                       conv_done_o,
    input wire logic                       threshold_int_o,
    input wire logic                       power_down_o
);
    import asf_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Fastest legal conversion is 13 ticks of 6 cycles, less tick phase
    localparam int MIN_CONV = 70;

    logic       cfg_wr;
    logic       cmd_wr;
    logic [9:0] conv_cyc;
    assign cfg_wr = wr_i && addr_i == CONFIG_ADDR;
    assign cmd_wr = wr_i && addr_i == CMD_ADDR;

    // Saturates so an idle stretch never wraps into a false short count
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || sample_o)
            conv_cyc <= 10'h000;
        else if (conv_cyc != 10'h3FF)
            conv_cyc <= conv_cyc + 10'h001;
    end

    property p_cfg_quiet;
        cfg_wr |=> !conv_done_o && !threshold_int_o && !sample_o;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet)
        else $error("config write raised done, interrupt or sample");

    property p_cmd_read;
        cmd_wr && wdata_i[CMD_READ_BIT] |=> !threshold_int_o && !sample_o;
    endproperty
    a_cmd_read: assert property (p_cmd_read)
        else $error("buffer read left interrupt or started sampling");

    property p_wake;
        sample_o |-> !power_down_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("sampling while still powered down");

    property p_pdown;
        $rose(conv_done_o) |-> power_down_o;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("conversion ended without power-down");

    property p_int_hold;
        threshold_int_o && !cfg_wr && !cmd_wr |=> threshold_int_o;
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("interrupt dropped without read or clear");

    property p_int_rise;
        $rose(threshold_int_o) |-> $rose(conv_done_o);
    endproperty
    a_int_rise: assert property (p_int_rise)
        else $error("interrupt rose away from a conversion end");

    property p_just;
        $changed(output_result_word_o) |-> output_result_word_o[1:0] == 2'h0;
    endproperty
    a_just: assert property (p_just)
        else $error("result word not left-justified");

    property p_conv_len;
        $rose(conv_done_o) |-> conv_cyc >= MIN_CONV;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion finished too early");
endmodule

bind asf_ctrl asf_ctrl_assertions chk
(
    .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .output_result_word_o, .sample_o, .conv_done_o,
    .threshold_int_o, .power_down_o
);

// ==== asf_host_model.sv ====
// Host serial port model: chip select, frame sync, start strobe, clock
`timescale 1ns/10ps
module asf_host_model
(
    input  wire logic mclk_i,
    output logic      cs_n_o,
    output logic      frame_sync_pulse_o,
    output logic      conversion_start_strobe_n_o,
    output logic      sclk_o
);
    initial
    begin
        cs_n_o = 1'b1;
        frame_sync_pulse_o = 1'b0;
        conversion_start_strobe_n_o = 1'b1;
        sclk_o = 1'b0;
    end

    // Kind 0 chip select, 1 frame sync, 2 start strobe
    // Serial clock runs only inside the frame, at a quarter of mclk
    task automatic frame(input int kind, input int half_clks);
        @(posedge mclk_i);
        cs_n_o <= (kind != 0);
        frame_sync_pulse_o <= (kind == 1);
        conversion_start_strobe_n_o <= (kind != 2);
        repeat (half_clks)
        begin
            repeat (2) @(posedge mclk_i);
            sclk_o <= ~sclk_o;
        end
        repeat (6) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        frame_sync_pulse_o <= 1'b0;
        conversion_start_strobe_n_o <= 1'b1;
        sclk_o <= 1'b0;
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            fails++; \
            $display("wrong value %s exp %h got %h", nm, ex, got); \
        end \
    end
module tb;
    import asf_pkg::*;
    logic              mclk_i, rst_i, wr_i, rd_i, sclk_i;
    logic              cs_n_i, frame_sync_pulse_i, conversion_start_strobe_n_i;
    logic [RES_W-1:0]  adc_result_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, rd_val;
    logic [WORD_W-1:0] output_result_word_o, w;
    logic [2:0]        channel_o;
    logic              sample_o, conv_done_o, threshold_int_o, power_down_o;
    logic [15:0]       lfsr_q;
    logic [WORD_W-1:0] exp_q[$];
    asf_cfg_t          cfg;
    int                fails = 0;
    int                n_checks = 0;

    asf_ctrl dut
    (
        .mclk_i, .rst_i, .cs_n_i, .frame_sync_pulse_i,
        .conversion_start_strobe_n_i, .sclk_i, .adc_result_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .output_result_word_o,
        .channel_o, .sample_o, .conv_done_o, .threshold_int_o, .power_down_o
    );
    asf_host_model host
    (
        .mclk_i,
        .cs_n_o                      (cs_n_i),
        .frame_sync_pulse_o          (frame_sync_pulse_i),
        .conversion_start_strobe_n_o (conversion_start_strobe_n_i),
        .sclk_o                      (sclk_i)
    );

    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [2:0] exp_ch(input logic [1:0] sel, input int p);
        case (sel)
            2'h1:    exp_ch = 3'((p % 4) * 2);
            2'h2:    exp_ch = 3'((p / 2) * 2);
            2'h3:    exp_ch = 3'(p % 4);
            default: exp_ch = 3'(p);
        endcase
    endfunction

    // Fill count at which the interrupt must be up
    function automatic int exp_thr(input logic [1:0] th);
        case (th)
            THR_3Q:   exp_thr = 6;
            THR_HALF: exp_thr = 4;
            THR_1Q:   exp_thr = 2;
            default:  exp_thr = DEPTH;
        endcase
    endfunction

    // Serial clock rises every 4 cycles here, so one tick is 16 cycles
    function automatic int exp_len();
        exp_len = (cfg.res12 ? CLKS_12BIT : CLKS_14BIT) *
                  (cfg.clk_ext ? SCLK_DIV * 4 : OSC_DIV);
    endfunction

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rd_val = rdata_o;
    endtask

    task automatic set_cfg(input logic [1:0] m, input logic [1:0] s,
                           input logic [1:0] th, input logic e);
        cfg = {e, e, th, s, m};
        exp_q.delete();
        bus_wr(CONFIG_ADDR, {8'h00, cfg});
        bus_rd(STATUS_ADDR);
        `CHK("config clears", 6'h00, {rd_val[7:4], rd_val[1:0]})
    endtask

    task automatic convert(input logic [2:0] ch);
        int t;
        int k;
        logic [RES_W-1:0] res;
        logic len_ok;
        lfsr_q = lfsr_next(lfsr_q);
        k = int'(lfsr_q % 16'h0003);
        // Pattern reads the same whichever 12 bits carry the short result
        res = cfg.res12 ? (lfsr_q[0] ? 14'h2AAA : 14'h1555) : lfsr_q[13:0];
        @(posedge mclk_i);
        adc_result_i <= res;
        fork
            host.frame(k, cfg.clk_ext ? 2 * SCLK_DIV * CLKS_14BIT + 20 : 0);
            begin
                t = 0;
                while (sample_o !== 1'b1 && t < 20)
                begin
                    tick();
                    t++;
                end
                `CHK("sample", 1'b1, sample_o)
                `CHK("channel", ch, channel_o)
                t = 0;
                while (conv_done_o !== 1'b1 && t < 600)
                begin
                    tick();
                    t++;
                end
                len_ok = t > exp_len() - 20 && t < exp_len() + 20;
                `CHK("length", 1'b1, len_ok)
                `CHK("power down", 1'b1, power_down_o)
            end
        join
        exp_q.push_back(cfg.res12 ? {res[11:0], 4'h0} : {res, 2'h0});
    endtask

    task automatic fill(input int n, input logic [2:0] ch, input logic held);
        logic e;
        for (int i = 0; i < n; i++)
        begin
            convert(cfg.mode == MODE_REPEAT ? ch : exp_ch(cfg.seq_sel, i));
            bus_rd(STATUS_ADDR);
            `CHK("fill", 4'(i + 1), rd_val[7:4])
            e = held || i + 1 >= exp_thr(cfg.thr);
            `CHK("interrupt", e, threshold_int_o)
        end
    endtask

    task automatic drain();
        bus_wr(CMD_ADDR, 16'h0008);
        `CHK("int cleared", 1'b0, threshold_int_o)
        while (exp_q.size() > 0)
        begin
            w = exp_q.pop_front();
            bus_rd(RESULT_ADDR);
            `CHK("result word", w, rd_val)
        end
        bus_rd(STATUS_ADDR);
        `CHK("fill drained", 4'h0, rd_val[7:4])
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Whole run needs under 8000 cycles
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        final_report();
    end

    initial
    begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        adc_result_i = 14'h0000;
        lfsr_q = 16'h001B;
        cfg = CFG_RESET;
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        bus_rd(STATUS_ADDR);
        `CHK("reset status", 16'h0004, rd_val)
        bus_rd(4'h2);
        `CHK("unmapped read", 16'h0000, rd_val)
        set_cfg(MODE_SWEEP, 2'h1, THR_HALF, 1'b0);
        fill(4, 3'h0, 1'b0);
        w = exp_q[0];
        `CHK("head word", w, output_result_word_o)
        repeat (10) tick();
        `CHK("word kept", w, output_result_word_o)
        bus_rd(CONFIG_ADDR);
        `CHK("config kept", cfg, rd_val[7:0])
        drain();
        $display("test 1 done");
        // Second sweep runs straight over the unread first one
        set_cfg(MODE_RSWEEP, 2'h3, THR_HALF, 1'b1);
        fill(4, 3'h0, 1'b0);
        exp_q.delete();
        fill(4, 3'h0, 1'b1);
        drain();
        $display("test 2 done");
        set_cfg(MODE_REPEAT, 2'h0, THR_FULL, 1'b0);
        w = {13'h0000, lfsr_q[2:0]};
        bus_wr(CMD_ADDR, w);
        fill(8, w[2:0], 1'b0);
        bus_wr(CMD_ADDR, w);
        `CHK("word stopped", 16'h0000, output_result_word_o)
        bus_rd(STATUS_ADDR);
        `CHK("abandon", 5'h00, {rd_val[7:4], rd_val[1]})
        exp_q.delete();
        fill(2, w[2:0], 1'b0);
        set_cfg(MODE_RSWEEP, 2'h0, THR_1Q, 1'b0);
        fill(2, 3'h0, 1'b0);
        set_cfg(MODE_SWEEP, 2'h2, THR_3Q, 1'b0);
        fill(6, 3'h0, 1'b0);
        set_cfg(MODE_SINGLE, 2'h0, THR_FULL, 1'b0);
        $display("test 3 done");
        bus_wr(CMD_ADDR, 16'h0003);
        convert(3'h3);
        `CHK("single done", 1'b1, conv_done_o)
        `CHK("single word", exp_q[0], output_result_word_o)
        $display("test 4 done");
        final_report();
    end
endmodule
